/* File: hdl/wtl_pkg.sv */
package wtl_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [3:0] WTL_ADR_SERVICE = 4'h0;
  localparam logic [3:0] WTL_ADR_TSEL = 4'h4;
  localparam logic [3:0] WTL_ADR_STATUS = 4'h8;

  localparam logic [7:0] WTL_KEY_FIRST = 8'h1e;
  localparam logic [7:0] WTL_KEY_SECOND = 8'he1;

  localparam int WTL_TSEL_W = 3;
  localparam logic [2:0] WTL_TSEL_RST = 3'h0;
  localparam int WTL_ST_EN_BIT = 0;
  localparam int WTL_ST_PD_BIT = 1;
  localparam int WTL_ST_WAKE_BIT = 2;

  // ***************************************************************
  // Counter and reset pulse
  // ***************************************************************
  localparam int WTL_BASE_W = 14;
  localparam int WTL_PRE_W = 7;
  localparam int WTL_CNT_W = WTL_BASE_W + WTL_PRE_W;
  localparam logic [WTL_CNT_W-1:0] WTL_BASE_PERIOD = 21'h004000;
  localparam logic [WTL_CNT_W-1:0] WTL_CNT_ONE = 21'h000001;
  localparam int WTL_PULSE_CYC = 96;
  localparam int WTL_PULSE_W = 7;
  localparam logic [WTL_PULSE_W-1:0] WTL_PULSE_LEN = 7'(WTL_PULSE_CYC);

  typedef enum logic [1:0] {WTL_RUN, WTL_PDOWN, WTL_WAKE} wtl_state_e;

  typedef struct packed {
    logic [3:0] adr;
    logic we;
    logic sel0;
    logic [7:0] dat;
  } wtl_wb_req_s;

endpackage

/* File: hdl/wtl_watchdog.sv */
`timescale 1ns/100ps
module wtl_watchdog
  import wtl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic power_down_i,
  input wire logic ext_int_en_i,
  input wire logic ext_int_n_i,
  output logic osc_stop_o,
  output logic wake_o,
  output logic rst_out_n_o
);

  // ***************************************************************
  // Interrupt pin synchroniser
  // ***************************************************************
  logic int_meta_q, int_sync_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_meta_q <= 1'b1;
      int_sync_q <= 1'b1;
    end else begin
      int_meta_q <= ext_int_n_i;
      int_sync_q <= int_meta_q;
    end
  end

  // ***************************************************************
  // Wishbone slave
  // ***************************************************************
  wtl_wb_req_s req;
  logic wr_go, svc_hit, sel_wr;
  logic ack_d, ack_q;
  logic [31:0] dat_d, dat_q;
  logic en_q, arm_q;
  logic [2:0] tsel_q;
  wtl_state_e st_q;

  assign req = '{adr: wb_adr_i, we: wb_we_i, sel0: wb_sel_i[0], dat: wb_dat_i[7:0]};
  // Writes land on the edge where the master sees ack
  assign wr_go = wb_cyc_i && wb_stb_i && ack_q && req.we && req.sel0;
  assign svc_hit = wr_go && (req.adr == WTL_ADR_SERVICE);
  assign sel_wr = wr_go && (req.adr == WTL_ADR_TSEL);

  always_comb begin
    ack_d = wb_cyc_i && wb_stb_i && !ack_q;
    dat_d = 32'h00000000;
    if (req.adr == WTL_ADR_TSEL) begin
      dat_d[WTL_TSEL_W-1:0] = tsel_q;
    end else if (req.adr == WTL_ADR_STATUS) begin
      dat_d[WTL_ST_EN_BIT] = en_q;
      dat_d[WTL_ST_PD_BIT] = (st_q == WTL_PDOWN);
      dat_d[WTL_ST_WAKE_BIT] = (st_q == WTL_WAKE);
    end else begin
      dat_d = 32'h00000000; // Service register is write only; unmapped reads zero
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ***************************************************************
  // Power-down and wake sequencing
  // ***************************************************************
  wtl_state_e st_d;
  logic ien_d, ien_q, osc_d, osc_q, wake_d, wake_q;

  always_comb begin
    st_d = st_q;
    ien_d = ien_q;
    osc_d = osc_q;
    wake_d = wake_q;
    case (st_q)
      WTL_RUN: begin
        if (power_down_i) begin
          st_d = WTL_PDOWN;
          ien_d = ext_int_en_i;
          osc_d = 1'b1;
        end
      end
      WTL_PDOWN: begin
        // Only an interrupt armed before entry may end power-down
        if (ien_q && !int_sync_q) begin
          st_d = WTL_WAKE;
          osc_d = 1'b0;
          wake_d = 1'b1;
        end
      end
      WTL_WAKE: begin
        // Oscillator settles while the line is low; counting waits for high
        if (int_sync_q) begin
          st_d = WTL_RUN;
          wake_d = 1'b0;
        end
      end
      default: begin
        st_d = WTL_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= WTL_RUN;
      ien_q <= 1'b0;
      osc_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ien_q <= ien_d;
      osc_q <= osc_d;
      wake_q <= wake_d;
    end
  end

  assign osc_stop_o = osc_q;
  assign wake_o = wake_q;

  // ***************************************************************
  // Watchdog counter and reset pulse
  // ***************************************************************
  logic [WTL_CNT_W-1:0] cnt_d, cnt_q, limit;
  logic [WTL_PULSE_W-1:0] pls_d, pls_q;
  logic en_d, arm_d, rstn_d, rstn_q, ovf, run;
  logic [2:0] tsel_d;

  // Prescaled terminal count; no divider needed since the step is a shift
  assign limit = (WTL_BASE_PERIOD << tsel_q) - WTL_CNT_ONE;
  // Frozen outside run state: clock is stopped or wake is pending
  assign run = en_q && (st_q == WTL_RUN) && (pls_q == '0);
  assign ovf = run && (cnt_q == limit);

  always_comb begin
    en_d = en_q;
    arm_d = arm_q;
    cnt_d = cnt_q;
    tsel_d = tsel_q;
    pls_d = pls_q;
    if (run) begin
      cnt_d = cnt_q + WTL_CNT_ONE;
    end
    if (sel_wr) begin
      tsel_d = req.dat[WTL_TSEL_W-1:0];
    end
    if (svc_hit) begin
      // Any other byte breaks the key pair
      if (req.dat == WTL_KEY_FIRST) begin
        arm_d = 1'b1;
      end else if (arm_q && req.dat == WTL_KEY_SECOND) begin
        arm_d = 1'b0;
        en_d = 1'b1;
        cnt_d = '0;
      end else begin
        arm_d = 1'b0;
      end
    end
    if (ovf) begin
      // Overflow resets the device, so watchdog state returns to reset
      en_d = 1'b0;
      arm_d = 1'b0;
      cnt_d = '0;
      tsel_d = WTL_TSEL_RST;
      pls_d = WTL_PULSE_LEN;
    end else if (pls_q != '0) begin
      pls_d = pls_q - 7'h01;
    end
    rstn_d = (pls_d == '0);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
      arm_q <= 1'b0;
      cnt_q <= '0;
      tsel_q <= WTL_TSEL_RST;
      pls_q <= '0;
      rstn_q <= 1'b1;
    end else begin
      en_q <= en_d;
      arm_q <= arm_d;
      cnt_q <= cnt_d;
      tsel_q <= tsel_d;
      pls_q <= pls_d;
      rstn_q <= rstn_d;
    end
  end

  assign rst_out_n_o = rstn_q;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [7:0] low_len_q;
  logic rst_seen_q;
  always_ff @(posedge clk_i) begin
    rst_seen_q <= rst_i;
    if (rst_i || rst_out_n_o) begin
      low_len_q <= 8'h00;
    end else begin
      low_len_q <= low_len_q + 8'h01;
    end
  end

  property p_tsel_reset;
    rst_seen_q |-> (tsel_q == WTL_TSEL_RST) && !en_q;
  endproperty
  a_tsel_reset: assert property (p_tsel_reset) else $error("select not zero after reset");

  property p_reserved_zero;
    wb_ack_o |-> wb_dat_o[31:WTL_TSEL_W] == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

  property p_limit;
    ovf |-> cnt_q == (WTL_BASE_PERIOD * (21'h000001 << tsel_q)) - 21'h000001;
  endproperty
  a_limit: assert property (p_limit) else $error("overflow at wrong count");

  property p_freeze;
    (st_q != WTL_RUN) && !svc_hit |=> $stable(cnt_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("counter moved while stopped");

  property p_stay_down;
    (st_q == WTL_PDOWN) && !(ien_q && !int_sync_q) |=> (st_q == WTL_PDOWN) && osc_stop_o;
  endproperty
  a_stay_down: assert property (p_stay_down) else $error("left power-down wrongly");

  property p_wake_hold;
    (st_q == WTL_WAKE) && !int_sync_q |=> (st_q == WTL_WAKE) && wake_o ##1 1'b1;
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake hold lost");

  property p_count;
    run && !ovf && !svc_hit |=> cnt_q == $past(cnt_q) + WTL_CNT_ONE;
  endproperty
  a_count: assert property (p_count) else $error("counter did not advance");

  property p_enable_key;
    $rose(en_q) |-> $past(svc_hit) && $past(arm_q);
  endproperty
  a_enable_key: assert property (p_enable_key) else $error("enabled without key pair");

  property p_no_disable;
    en_q && !ovf |=> en_q;
  endproperty
  a_no_disable: assert property (p_no_disable) else $error("watchdog disabled by software");

  property p_ovf_pulse;
    ovf |=> !rst_out_n_o [*8];
  endproperty
  a_ovf_pulse: assert property (p_ovf_pulse) else $error("no reset pulse on overflow");

  property p_pulse_len;
    $rose(rst_out_n_o) |-> low_len_q == 8'(WTL_PULSE_CYC);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong");

  c_overflow: cover property (ovf);
  c_wake: cover property ((st_q == WTL_WAKE) ##[1:50] (st_q == WTL_RUN));
  c_enable: cover property ($rose(en_q));

endmodule

/* File: bench/wtl_watchdog_tb_top.sv */
`timescale 1ns/100ps
module wtl_watchdog_tb_top;
  import wtl_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic pd = 1'b0;
  logic int_en = 1'b0;
  logic int_n = 1'b1;
  logic osc_stop;
  logic wake;
  logic rst_n;
  int fails = 0;
  int comparisons = 0;
  int n;

  always #4 clk_i = ~clk_i;

  wtl_watchdog i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .power_down_i(pd), .ext_int_en_i(int_en), .ext_int_n_i(int_n),
    .osc_stop_o(osc_stop), .wake_o(wake), .rst_out_n_o(rst_n));

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_cyc(input int c);
    repeat (c) @(posedge clk_i);
  endtask

  // Read data is taken at the ack edge, before the slave's own update lands
  // No local limit: only the bench watchdog ends a hung request
  task automatic wb(input logic [3:0] a, input logic w, input logic [7:0] d,
                    output logic [31:0] r);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic do_rst();
    @(posedge clk_i);
    rst_i <= 1'b1;
    pd <= 1'b0;
    int_n <= 1'b1;
    int_en <= 1'b0;
    wait_cyc(2);
    rst_i <= 1'b0;
  endtask

  task automatic key(input logic [7:0] d);
    logic [31:0] r;
    wb(WTL_ADR_SERVICE, 1'b1, d, r);
  endtask

  // Cycles until the reset pulse starts, bounded
  task automatic until_low(output int c);
    c = 0;
    while (rst_n === 1'b1 && c < 40000) begin
      @(posedge clk_i);
      c++;
    end
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_regs();
    logic [31:0] r;
    wb(WTL_ADR_TSEL, 1'b0, 8'h0, r);
    chk(r, 32'h0);
    wb(WTL_ADR_STATUS, 1'b0, 8'h0, r);
    chk(r, 32'h0);
    wb(WTL_ADR_TSEL, 1'b1, 8'h07, r);
    wb(WTL_ADR_TSEL, 1'b0, 8'h0, r);
    chk(r, 32'h7);
    wb(WTL_ADR_SERVICE, 1'b0, 8'h0, r);
    chk(r, 32'h0);
    wb(4'hc, 1'b0, 8'h0, r);
    chk(r, 32'h0);
  endtask

  task automatic t_overflow();
    logic [31:0] r;
    do_rst();
    key(WTL_KEY_FIRST);
    key(WTL_KEY_SECOND);
    wb(WTL_ADR_STATUS, 1'b0, 8'h0, r);
    chk(r[0], 32'h1);
    until_low(n);
    chk(32'(n > 16360 && n < 16390), 32'h1);
    n = 0;
    while (rst_n === 1'b0 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    chk(n, 32'd96);
    wb(WTL_ADR_STATUS, 1'b0, 8'h0, r);
    chk(r[0], 32'h0);
  endtask

  // A broken pair must not restart the count
  task automatic t_service();
    logic [31:0] r;
    do_rst();
    key(WTL_KEY_FIRST);
    key(WTL_KEY_SECOND);
    wait_cyc(10000);
    key(WTL_KEY_FIRST);
    key(WTL_KEY_SECOND);
    int_en <= 1'b1;
    pd <= 1'b1;
    wait_cyc(3);
    pd <= 1'b0;
    int_n <= 1'b0;
    wait_cyc(20);
    wb(WTL_ADR_STATUS, 1'b0, 8'h0, r);
    chk(r, 32'h5);
    int_n <= 1'b1;
    wait_cyc(6);
    key(WTL_KEY_FIRST);
    key(WTL_KEY_SECOND);
    wait_cyc(10000);
    chk(rst_n, 32'h1);
    key(WTL_KEY_FIRST);
    key(8'h55);
    key(WTL_KEY_SECOND);
    until_low(n);
    chk(32'(n > 6372 && n < 6380), 32'h1);
  endtask

  task automatic t_power();
    logic [31:0] r;
    do_rst();
    wb(WTL_ADR_TSEL, 1'b1, 8'h01, r);
    key(WTL_KEY_FIRST);
    key(WTL_KEY_SECOND);
    wait_cyc(20000);
    chk(rst_n, 32'h1);
    int_en <= 1'b1;
    pd <= 1'b1;
    wait_cyc(3);
    pd <= 1'b0;
    chk(osc_stop, 32'h1);
    wb(WTL_ADR_STATUS, 1'b0, 8'h0, r);
    chk(r, 32'h3);
    wait_cyc(8000);
    chk(rst_n, 32'h1);
    int_n <= 1'b0;
    wait_cyc(6);
    chk({wake, osc_stop}, 32'h2);
    wait_cyc(8000);
    chk(rst_n, 32'h1);
    int_n <= 1'b1;
    wait_cyc(6);
    chk(wake, 32'h0);
    until_low(n);
    chk(32'(n > 12700 && n < 12780), 32'h1);
  endtask

  // Without an enabled interrupt only reset ends power-down
  task automatic t_no_wake();
    do_rst();
    pd <= 1'b1;
    wait_cyc(3);
    pd <= 1'b0;
    int_n <= 1'b0;
    wait_cyc(10);
    chk(osc_stop, 32'h1);
    do_rst();
    wait_cyc(2);
    chk(osc_stop, 32'h0);
  endtask

  task automatic end_sim();
    if (fails == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    do_rst();
    t_regs();
    t_overflow();
    t_service();
    t_power();
    t_no_wake();
    end_sim();
  end

  // Longest path is about 92k cycles; allow some margin
  initial begin
    #800000;
    fails++;
    end_sim();
  end
endmodule
